// ==== blit_pkg.sv ====
// Shared constants and carriers for the block-transfer engine.
// Assumes one clock domain and an indexed 8-bit register port.
`default_nettype none
package blit_pkg;
  // Register indices
  localparam logic [7:0] IDX_MODE  = 8'h30;
  localparam logic [7:0] IDX_START = 8'h31;
  localparam logic [7:0] IDX_ROP   = 8'h32;
  localparam logic [7:0] IDX_TC_LO = 8'h34;
  localparam logic [7:0] IDX_TC_HI = 8'h35;
  // Mode register fields
  localparam int MODE_EXPAND = 7;
  localparam int MODE_WIDE   = 4;
  localparam int MODE_TC_EN  = 3;
  localparam int MODE_SRC_SYS = 2;
  localparam int MODE_DST_SYS = 1;
  localparam int MODE_DEC    = 0;
  // Start/status register fields
  localparam int SS_PROGRESS = 3;
  localparam int SS_RESET    = 2;
  localparam int SS_START    = 1;
  localparam int SS_BUSY     = 0;
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  // Raster operation codes
  localparam logic [7:0] ROP_ZERO  = 8'h00;
  localparam logic [7:0] ROP_ONE   = 8'h0E;
  localparam logic [7:0] ROP_S     = 8'h0D;
  localparam logic [7:0] ROP_D     = 8'h06;
  localparam logic [7:0] ROP_NS    = 8'hD0;
  localparam logic [7:0] ROP_ND    = 8'h0B;
  localparam logic [7:0] ROP_SAD   = 8'h05;
  localparam logic [7:0] ROP_SAND  = 8'h09;
  localparam logic [7:0] ROP_NSAD  = 8'h50;
  localparam logic [7:0] ROP_NOR   = 8'h90;
  localparam logic [7:0] ROP_OR    = 8'h6D;
  localparam logic [7:0] ROP_SOND  = 8'hAD;
  localparam logic [7:0] ROP_NSOD  = 8'hD6;
  localparam logic [7:0] ROP_NAND  = 8'hDA;
  localparam logic [7:0] ROP_XOR   = 8'h59;
  localparam logic [7:0] ROP_XNOR  = 8'h95;
  // Sizes
  localparam int ADDR_W     = 21;
  localparam int FIFO_DEPTH = 8;
  localparam logic [2:0] LAST_BIT = 3'd7;

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_SUSP} eng_state_e;

  // One pixel on its way to the destination
  typedef struct packed {
    logic              to_host;
    logic              wen;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       data;
  } pixel_s;
endpackage : blit_pkg
`default_nettype wire

// ==== blit_engine_control.sv ====
// Block-transfer engine: indexed registers, raster operation, colour
// expansion, transparency and start/suspend/reset control, plus the
// output FIFO. Assumes every input comes from logic on clk.
//
// Behaviour
// - Expansion makes 16-bit or 8-bit pixels by width
// - Transparency compare width follows width select
// - Transparency enabled: matching results are not written
// - Transparency disabled: every result is written
// - Source bit picks host or display memory
// - Destination bit picks host or display memory
// - Direction bit decrements or increments addresses
// - Progress flag set on start, cleared by reset
// - Reset bit aborts engine and clears progress
// - Start bit begins transfer, self-clears on finish
// - Clearing start suspends at line end, resumable
// - Status bit shows transfer in progress
// - Eight-bit code selects constant and copy functions
// - Remaining codes select the logic functions
// - Sixteen-bit transparent colour in two bytes
// - Expanded source, most significant bit first
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module blit_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             ce,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  // Shift register: the head always sits in entry 0, so out_valid and out_data are flops
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [DEPTH-1:0] vld_q;
  logic [DEPTH-1:0] vld_d;
  logic             placed;
  wire              pop  = out_ready & vld_q[0];
  wire              push = in_valid & in_ready;

  assign in_ready  = ~vld_q[DEPTH-1] | pop;
  assign out_valid = vld_q[0];
  assign out_data  = mem_q[0];

  always_comb begin
    placed = 1'b0;
    mem_d  = mem_q;
    vld_d  = vld_q;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        mem_d[i] = mem_q[i+1];
      end
      vld_d = {1'b0, vld_q[DEPTH-1:1]};
    end
    if (push) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!vld_d[i] && !placed) begin
          mem_d[i] = in_data;
          vld_d[i] = 1'b1;
          placed   = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      vld_q <= '0;
    end else if (ce) begin
      vld_q <= vld_d;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      mem_q <= mem_d;
    end
  end
endmodule : blit_fifo

////////////////////////////////////////////////////////////////////////////////
module blit_engine_control import blit_pkg::*; (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              ce,
  // Indexed register port
  input  wire logic [7:0]        reg_index,
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        rdata_q,
  // Transfer geometry and expansion colours
  input  wire logic [11:0]       line_pixels,
  input  wire logic [9:0]        line_total,
  input  wire logic [ADDR_W-1:0] src_start,
  input  wire logic [ADDR_W-1:0] dst_start,
  input  wire logic [15:0]       fg_colour,
  input  wire logic [15:0]       bg_colour,
  // Operand fetch
  input  wire logic              mem_free,
  output logic                   fetch_req_q,
  output logic      [ADDR_W-1:0] src_addr_q,
  output logic      [ADDR_W-1:0] dst_addr_q,
  output logic                   src_from_host,
  input  wire logic              fetch_valid,
  input  wire logic [15:0]       src_data,
  input  wire logic [15:0]       dst_data,
  // Progress
  output logic      [9:0]        lines_done_q,
  // Destination stream
  output logic                   out_valid,
  input  wire logic              out_ready,
  output pixel_s                 out_pixel
);
  logic [7:0]  mode_q;
  logic [7:0]  rop_q;
  logic [7:0]  tc_lo_q;
  logic [7:0]  tc_hi_q;
  logic        start_q;
  logic        rst_q;
  logic        progress_q;
  logic        busy_q;
  eng_state_e  state_q;
  logic [11:0] px_q;
  logic [2:0]  bit_q;
  logic [7:0]  sbyte_q;
  logic        fifo_ready;

  function automatic logic [15:0] rop_apply(input logic [7:0] code,
                                            input logic [15:0] s,
                                            input logic [15:0] d);
    case (code)
      ROP_ZERO: rop_apply = 16'h0000;
      ROP_ONE:  rop_apply = 16'hFFFF;
      ROP_S:    rop_apply = s;
      ROP_D:    rop_apply = d;
      ROP_NS:   rop_apply = ~s;
      ROP_ND:   rop_apply = ~d;
      ROP_SAD:  rop_apply = s & d;
      ROP_SAND: rop_apply = s & ~d;
      ROP_NSAD: rop_apply = ~s & d;
      ROP_NOR:  rop_apply = ~(s | d);
      ROP_OR:   rop_apply = s | d;
      ROP_SOND: rop_apply = s | ~d;
      ROP_NSOD: rop_apply = ~s | d;
      ROP_NAND: rop_apply = ~(s & d);
      ROP_XOR:  rop_apply = s ^ d;
      ROP_XNOR: rop_apply = ~(s ^ d);
      default:  rop_apply = s;
    endcase
  endfunction : rop_apply

  function automatic logic [ADDR_W-1:0] addr_step(input logic [ADDR_W-1:0] a,
                                                  input logic dec,
                                                  input logic [ADDR_W-1:0] n);
    addr_step = dec ? a - n : a + n;
  endfunction : addr_step

  // Register decode
  wire wr_mode  = reg_wr & (reg_index == IDX_MODE);
  wire wr_start = reg_wr & (reg_index == IDX_START);
  wire wr_rop   = reg_wr & (reg_index == IDX_ROP);
  wire wr_tc_lo = reg_wr & (reg_index == IDX_TC_LO);
  wire wr_tc_hi = reg_wr & (reg_index == IDX_TC_HI);
  wire abort    = rst_q | (wr_start & reg_wdata[SS_RESET]);
  wire        wide    = mode_q[MODE_WIDE];
  wire        expand  = mode_q[MODE_EXPAND];
  wire        dec     = mode_q[MODE_DEC];
  wire [15:0] tcolour = {tc_hi_q, tc_lo_q};
  wire [15:0] pmask   = wide ? 16'hFFFF : 16'h00FF;
  // Colour expansion, first pixel from the top bit of each byte
  wire [7:0]  cur_byte = (bit_q == 3'd0) ? src_data[7:0] : sbyte_q;
  wire        exp_bit  = cur_byte[LAST_BIT - bit_q];
  wire [15:0] exp_pix  = (exp_bit ? fg_colour : bg_colour) & pmask;
  wire [15:0] s_pix    = expand ? exp_pix : (src_data & pmask);
  wire [15:0] d_pix    = dst_data & pmask;
  wire [15:0] result   = rop_apply(rop_q, s_pix, d_pix) & pmask;
  wire        tc_match = wide ? (result == tcolour)
                              : (result[7:0] == tc_lo_q);
  wire        pix_wen  = ~(mode_q[MODE_TC_EN] & tc_match);
  wire [ADDR_W-1:0] pix_bytes = wide ? ADDR_W'(2) : ADDR_W'(1);
  wire              byte_end  = (bit_q == LAST_BIT);
  wire              last_px   = (px_q == line_pixels - 12'd1);
  wire              last_line = (lines_done_q == line_total - 10'd1);
  wire              take      = (state_q == ST_WAIT) & fetch_valid;
  wire              finish    = take & last_px & last_line;
  wire              issue     = (state_q == ST_ISSUE) & fifo_ready & mem_free & ~abort;
  wire pixel_s push_pix = '{mode_q[MODE_DST_SYS], pix_wen, dst_addr_q, result};
  assign src_from_host  = mode_q[MODE_SRC_SYS];
  wire [7:0] status = {4'h0, progress_q, rst_q, start_q, busy_q};
  wire [7:0] rd_mux = (reg_index == IDX_MODE)  ? mode_q  :
                      (reg_index == IDX_START) ? status  :
                      (reg_index == IDX_ROP)   ? rop_q   :
                      (reg_index == IDX_TC_LO) ? tc_lo_q :
                      (reg_index == IDX_TC_HI) ? tc_hi_q : 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q  <= REG_RESET;
      rop_q   <= REG_RESET;
      tc_lo_q <= REG_RESET;
      tc_hi_q <= REG_RESET;
      rst_q   <= 1'b0;
      rdata_q <= REG_RESET;
    end else if (ce) begin
      if (wr_mode)  mode_q  <= reg_wdata;
      if (wr_rop)   rop_q   <= reg_wdata;
      if (wr_tc_lo) tc_lo_q <= reg_wdata;
      if (wr_tc_hi) tc_hi_q <= reg_wdata;
      if (wr_start) rst_q   <= reg_wdata[SS_RESET];
      rdata_q <= rd_mux;
    end
  end

  // Software write of start wins over the clear at completion
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      start_q <= 1'b0;
      busy_q  <= 1'b0;
    end else if (ce) begin
      if (abort) begin
        start_q <= 1'b0;
        busy_q  <= 1'b0;
      end else begin
        if (finish) begin
          start_q <= 1'b0;
          busy_q  <= 1'b0;
        end else if (state_q == ST_IDLE && start_q) begin
          busy_q  <= 1'b1;
        end
        if (wr_start) start_q <= reg_wdata[SS_START];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      progress_q <= 1'b0;
    end else if (ce) begin
      if (abort) progress_q <= 1'b0;
      else if (state_q == ST_IDLE && start_q) progress_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q      <= ST_IDLE;
      fetch_req_q  <= 1'b0;
      px_q         <= '0;
      bit_q        <= '0;
      sbyte_q      <= '0;
      lines_done_q <= '0;
      src_addr_q   <= '0;
      dst_addr_q   <= '0;
    end else if (ce) begin
      fetch_req_q <= issue;
      case (state_q)
        ST_IDLE: begin
          if (start_q && !abort) begin
            src_addr_q   <= src_start;
            dst_addr_q   <= dst_start;
            px_q         <= '0;
            bit_q        <= '0;
            lines_done_q <= '0;
            state_q      <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (abort) state_q <= ST_IDLE;
          else if (issue) state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (abort) begin
            state_q <= ST_IDLE;
          end else if (fetch_valid) begin
            dst_addr_q <= addr_step(dst_addr_q, dec, pix_bytes);
            if (!expand) src_addr_q <= addr_step(src_addr_q, dec, pix_bytes);
            else if (byte_end || last_px) src_addr_q <= addr_step(src_addr_q, dec, ADDR_W'(1));
            if (bit_q == 3'd0) sbyte_q <= src_data[7:0];
            bit_q <= (last_px || byte_end) ? 3'd0 : bit_q + 3'd1;
            if (last_px) begin
              px_q         <= '0;
              lines_done_q <= lines_done_q + 10'd1;
              if (last_line) state_q <= ST_IDLE;
              else if (!start_q) state_q <= ST_SUSP;
              else state_q <= ST_ISSUE;
            end else begin
              px_q    <= px_q + 12'd1;
              state_q <= ST_ISSUE;
            end
          end
        end
        ST_SUSP: begin
          if (abort) state_q <= ST_IDLE;
          else if (start_q) state_q <= ST_ISSUE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  blit_fifo #(
    .WIDTH ($bits(pixel_s)),
    .DEPTH (FIFO_DEPTH)
  ) u_out_fifo (
    .clk       (clk),
    .arst_n    (arst_n),
    .ce        (ce),
    .in_valid  (take),
    .in_ready  (fifo_ready),
    .in_data   (push_pix),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_pixel)
  );
endmodule : blit_engine_control
`default_nettype wire

// ==== blit_engine_control_checker.sv ====
// Port checker for the block-transfer engine, bound to its top module.
// Assumes ce stays high and status reads hold reg_index steady.
`default_nettype none
module blit_engine_control_checker import blit_pkg::*; (
  // Clock and reset
  input wire logic       clk,
  input wire logic       arst_n,
  // Register port
  input wire logic [7:0] reg_index,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] rdata_q,
  // Engine
  input wire logic       mem_free,
  input wire logic       fetch_req_q,
  input wire logic       fetch_valid,
  input wire logic       src_from_host,
  input wire logic       out_valid,
  input wire pixel_s     out_pixel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [1:0] idx_q;
  logic       rst_wr_q;
  logic       tc_en_q;
  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_q    <= 2'h0;
      rst_wr_q <= 1'b0;
      tc_en_q  <= 1'b0;
    end else begin
      idx_q    <= {idx_q[0], reg_index == IDX_START};
      rst_wr_q <= reg_wr && reg_index == IDX_START && reg_wdata[SS_RESET];
      if (reg_wr && reg_index == IDX_MODE) tc_en_q <= reg_wdata[MODE_TC_EN];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_free_fetch: assert property ($rose(fetch_req_q) |-> $past(mem_free))
    else $error("fetch without a free memory cycle");
  a_answer_gap: assert property (fetch_valid |=> !fetch_req_q)
    else $error("fetch too soon after answer");
  a_abort_now: assert property (rst_wr_q |=> !fetch_req_q [*3])
    else $error("fetch after engine reset");
  a_clear_together: assert property (idx_q == 2'h3 && $fell(rdata_q[SS_BUSY])
    |-> $fell(rdata_q[SS_START])) else $error("busy cleared apart from start");
  a_busy_progress: assert property (idx_q[0] && rdata_q[SS_BUSY]
    |-> rdata_q[SS_PROGRESS]) else $error("busy without progress");
  a_progress_hold: assert property (idx_q == 2'h3 && $fell(rdata_q[SS_PROGRESS])
    |-> $past(rst_wr_q)) else $error("progress cleared without reset");
  a_src_select: assert property (reg_wr && reg_index == IDX_MODE
    |=> src_from_host == $past(reg_wdata[MODE_SRC_SYS])) else $error("source select");
  a_write_all: assert property (out_valid && !tc_en_q |-> out_pixel.wen)
    else $error("pixel suppressed with compare off");
  c_answer: cover property (fetch_valid);
  c_abort: cover property (rst_wr_q);
  c_masked: cover property (out_valid && !out_pixel.wen);
endmodule : blit_engine_control_checker
bind blit_engine_control blit_engine_control_checker u_chk (
  .clk, .arst_n, .reg_index, .reg_wr, .reg_wdata, .rdata_q, .mem_free,
  .fetch_req_q, .fetch_valid, .src_from_host, .out_valid, .out_pixel
);
`default_nettype wire

// ==== blit_mem_model.sv ====
// Display memory model answering one operand fetch at a time.
// Slow mode withholds every other memory cycle and answers late.
`default_nettype none
module blit_mem_model (
  // Clock
  input wire logic         clk,
  input wire logic         arst_n,
  // Control
  input wire logic         slow,
  input wire logic [15:0]  s_val,
  input wire logic [15:0]  d_val,
  // Fetch port
  input wire logic         fetch_req_q,
  output logic             mem_free,
  output logic             fetch_valid,
  output logic [15:0]      src_data,
  output logic [15:0]      dst_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  logic       pend_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {pend_q, cnt_q, fetch_valid, mem_free} <= 5'h00;
    end else begin
      mem_free    <= slow ? ~mem_free : 1'b1;
      fetch_valid <= 1'b0;
      if (fetch_req_q) {pend_q, cnt_q} <= {1'b1, slow ? 2'h3 : 2'h0};
      else if (pend_q && cnt_q != 2'h0) cnt_q <= cnt_q - 2'h1;
      else if (pend_q) {pend_q, fetch_valid} <= 2'h1;
    end
  end
  // Data lines carry garbage outside the answer cycle
  assign src_data = fetch_valid ? s_val : ~s_val;
  assign dst_data = fetch_valid ? d_val : ~d_val;
endmodule : blit_mem_model
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the block-transfer engine.
// Assumes the memory model on the fetch port; ce is held high.
`default_nettype none
module testbench import blit_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, ce, reg_wr, fetch_req_q, src_from_host, fetch_valid, mem_free;
  logic out_valid, out_ready, slow;
  logic [7:0] reg_index, reg_wdata, rdata_q, v;
  logic [11:0] line_pixels;
  logic [9:0] line_total, lines_done_q;
  logic [ADDR_W-1:0] src_start, dst_start, src_addr_q, dst_addr_q;
  logic [15:0] fg_colour, bg_colour, src_data, dst_data, s_val, d_val, e, m;
  pixel_s out_pixel;
  pixel_s pix [2];
  int miscompares, n_checks, n;
  localparam logic [7:0] CODES [16] = '{ROP_ZERO, ROP_ONE, ROP_S, ROP_D, ROP_NS, ROP_ND,
    ROP_SAD, ROP_SAND, ROP_NSAD, ROP_NOR, ROP_OR, ROP_SOND, ROP_NSOD, ROP_NAND, ROP_XOR, ROP_XNOR};
  // Result bit per {source, destination} pair for each code
  localparam logic [3:0] TT [16] = '{4'h0, 4'hF, 4'hC, 4'hA, 4'h3, 4'h5, 4'h8, 4'h4,
    4'h2, 4'h1, 4'hE, 4'hD, 4'hB, 4'h7, 4'h6, 4'h9};
  localparam logic [7:0] HI [4] = '{8'hC3, 8'hC3, 8'hA5, 8'h00};
  localparam logic [7:0] MD [4] = '{8'h18, 8'h10, 8'h08, 8'h18};
  blit_engine_control u_dut (.clk, .arst_n, .ce, .reg_index, .reg_wr, .reg_wdata, .rdata_q,
    .line_pixels, .line_total, .src_start, .dst_start, .fg_colour, .bg_colour, .mem_free,
    .fetch_req_q, .src_addr_q, .dst_addr_q, .src_from_host, .fetch_valid, .src_data,
    .dst_data, .lines_done_q, .out_valid, .out_ready, .out_pixel);
  blit_mem_model u_mem (.clk, .arst_n, .slow, .s_val, .d_val, .fetch_req_q, .mem_free,
    .fetch_valid, .src_data, .dst_data);
  always #12.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [20:0] s, input logic [20:0] x);
    n_checks++;
    if (s !== x) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    {reg_index, reg_wdata, reg_wr} = {i, d, 1'b1};
    @(negedge clk);
    reg_wr = 1'b0;
    @(negedge clk);
  endtask : wr
  task automatic rc(input logic [7:0] i, input logic [7:0] x);
    reg_index = i;
    repeat (2) @(negedge clk);
    chk($sformatf("reg %h", i), rdata_q, x);
  endtask : rc
  task automatic blit(input logic [7:0] md, input logic [7:0] op);
    n = 0;
    wr(IDX_MODE, md);
    wr(IDX_ROP, op);
    wr(IDX_START, 8'h02);
    for (int k = 0; k < 300 && n < 2; k++) begin
      if (out_valid === 1'b1) pix[n++] = out_pixel;
      @(negedge clk);
    end
    chk("pixels", n, 2);
    reg_index = IDX_START;
    for (int k = 0; k < 100 && rdata_q[SS_BUSY] !== 1'b0; k++) @(negedge clk);
    rc(IDX_START, 8'h08);
  endtask : blit
  task automatic results;
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    results();
  end
  initial begin
    {clk, arst_n, ce, reg_wr, reg_index, reg_wdata, out_ready, slow} = {3'b001, 17'h0, 2'b10};
    {line_pixels, line_total, src_start, dst_start} = {12'h2, 10'h1, 21'h100, 21'h200};
    {fg_colour, bg_colour, s_val, d_val} = {16'hF00F, 16'h0BB0, 16'hC3A5, 16'h5A3C};
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    foreach (MD[i]) rc(IDX_MODE + 8'(i), 8'h00);
    rc(IDX_TC_HI, 8'h00);
    wr(IDX_TC_LO, 8'hA5);
    wr(IDX_START, 8'h09);
    rc(IDX_START, 8'h00);
    rc(IDX_TC_LO, 8'hA5);
    foreach (CODES[k]) begin
      slow = k[0];
      blit(8'h10, CODES[k]);
      foreach (e[b]) e[b] = TT[k][{s_val[b], d_val[b]}];
      chk("rop", pix[0].data, e);
      chk("rop", pix[1].data, e);
    end
    chk("first addr", pix[0].addr, dst_start);
    chk("src addr", src_addr_q, src_start + 21'h4);
    chk("dst addr", dst_addr_q, dst_start + 21'h4);
    chk("step up", pix[1].addr > pix[0].addr, 1);
    foreach (MD[i]) begin
      wr(IDX_TC_HI, HI[i]);
      blit(MD[i], ROP_S);
      chk("wen", {pix[0].wen, pix[1].wen}, {2{i[0]}});
    end
    for (int w = 0; w < 2; w++) begin
      blit(w ? 8'h90 : 8'h80, ROP_S);
      m = w ? 16'hFFFF : 16'h00FF;
      chk("expand", pix[0].data & m, fg_colour & m);
      chk("expand", pix[1].data & m, bg_colour & m);
    end
    wr(IDX_TC_LO, bg_colour[7:0]);
    wr(IDX_TC_HI, bg_colour[15:8]);
    blit(8'h98, ROP_S);
    chk("see-through", {pix[0].wen, pix[1].wen}, 2'b10);
    blit(8'h14, ROP_S);
    chk("host src", src_from_host, 1);
    blit(8'h12, ROP_S);
    chk("host dst", pix[0].to_host, 1);
    blit(8'h11, ROP_S);
    chk("step down", pix[1].addr < pix[0].addr, 1);
    {line_pixels, line_total} = {12'h3, 10'h3};
    wr(IDX_START, 8'h02);
    for (int k = 0; k < 100 && out_valid !== 1'b1; k++) @(negedge clk);
    wr(IDX_START, 8'h00);
    repeat (40) @(negedge clk);
    rc(IDX_START, 8'h09);
    chk("lines", lines_done_q, 1);
    blit(8'h10, ROP_S);
    chk("lines", lines_done_q, 3);
    {out_ready, line_pixels, line_total} = {1'b0, 12'd20, 10'h1};
    wr(IDX_START, 8'h02);
    n = 0;
    repeat (80) @(negedge clk) n += fetch_req_q;
    chk("fill", n, FIFO_DEPTH);
    wr(IDX_START, 8'h04);
    rc(IDX_START, 8'h04);
    wr(IDX_START, 8'h00);
    out_ready = 1'b1;
    for (n = 0; out_valid === 1'b1 && n < 20; n++) @(negedge clk);
    chk("drain", n, FIFO_DEPTH);
    line_pixels = 12'h2;
    blit(8'h10, ROP_S);
    chk("restart", pix[0].data, s_val);
    results();
  end
endmodule : testbench
`default_nettype wire
